// File: rtl/sss_top.sv
`timescale 1ns/1ps
module sss_top #(
   parameter int ADDR_W = sss_pkg::ADDR_W_DEF,
   parameter int LANES  = sss_pkg::LANES_DEF,
   parameter int LANE_W = sss_pkg::LANE_W_DEF
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // chip enables
   input  wire logic                     chip_enable_first_low_n,
   input  wire logic                     chip_enable_second_high,
   input  wire logic                     chip_enable_third_low_n,
   // address strobes and address
   input  wire logic                     processor_address_strobe_n,
   input  wire logic                     controller_address_strobe_n,
   input  wire logic [ADDR_W-1:0]        addr,
   // write strobes
   input  wire logic                     global_write_strobe_n,
   input  wire logic                     byte_write_gate_n,
   input  wire logic [LANES-1:0]         per_lane_write_select_n,
   // sleep
   input  wire logic                     sleep_request,
   // data pins
   input  wire logic [LANES*LANE_W-1:0]  dq_in,
   output logic      [LANES*LANE_W-1:0]  dq_out,
   output logic                          dq_oe_n,
   // status
   output logic                          sleeping
);
   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   initial
   begin
      if (ADDR_W < 1 || ADDR_W > 20 || LANES < 1 || LANE_W < 1)
      begin
         $error("sss_top: unsupported geometry");
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic                    selected;
   logic                    strobe;
   logic                    wr_full;
   logic                    wr_bytes;
   logic [LANES-1:0]        lane_en;
   logic                    wr_any;
   sss_pkg::sss_state_t     state;
   sss_pkg::sss_state_t     next_state;
   logic [LANES*LANE_W-1:0] rd_data;

   // three-enable chip select
   assign selected = (chip_enable_first_low_n == sss_pkg::ASSERTED_LOW)
      && (chip_enable_second_high == sss_pkg::ASSERTED_HIGH)
      && (chip_enable_third_low_n == sss_pkg::ASSERTED_LOW);
   assign strobe = !processor_address_strobe_n
      || !controller_address_strobe_n;
   // global strobe wins over byte gate
   assign wr_full = !global_write_strobe_n
      || (!byte_write_gate_n && !(|per_lane_write_select_n));
   assign wr_bytes = global_write_strobe_n && !byte_write_gate_n;
   assign lane_en = wr_full ? {LANES{1'h1}}
      : (wr_bytes ? ~per_lane_write_select_n : {LANES{1'h0}});
   // sleep only honoured from deselect; controller must deselect first
   assign wr_any = selected && !sleep_request && (|lane_en);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   sss_mem #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_mem (
      .core_clk (core_clk),
      .wr_en    (wr_any),
      .lane_en  (lane_en),
      .addr     (addr),
      .wr_data  (dq_in),
      .rd_data  (rd_data)
   );

   // ----------------------------------------------------------------
   // access state
   // ----------------------------------------------------------------
   // next state: writes park the bus, only a strobed read reopens it
   always_comb
   begin
      next_state = state;
      case (state)
         sss_pkg::SSS_SLEEP:
         begin
            if (!sleep_request)
            begin
               next_state = sss_pkg::SSS_IDLE;
            end
         end
         default:
         begin
            if (sleep_request && !selected)
            begin
               next_state = sss_pkg::SSS_SLEEP;
            end
            else if (wr_any)
            begin
               next_state = sss_pkg::SSS_WRITE;
            end
            else if (selected && strobe && !sleep_request)
            begin
               next_state = sss_pkg::SSS_READ;
            end
            else if (!selected && strobe)
            begin
               next_state = sss_pkg::SSS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state <= sss_pkg::SSS_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // read data straight from the memory register
   assign dq_out   = rd_data;
   // bus driven only while a read is open
   assign dq_oe_n  = (state != sss_pkg::SSS_READ);
   assign sleeping = (state == sss_pkg::SSS_SLEEP);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // write parking: once written, only a strobed read reopens the bus
   AST_WRITE_PARKS: assert property (
      @(posedge core_clk) disable iff (rst)
      wr_any |=> dq_oe_n)
      else $error("bus driven after write");

   AST_NO_STROBE_STAYS_HIZ: assert property (
      @(posedge core_clk) disable iff (rst)
      (state == sss_pkg::SSS_WRITE && !strobe && !sleep_request
       && !wr_any) |=> dq_oe_n)
      else $error("bus reopened without strobe");

   // a read strobed on the sleep exit edge is dropped on purpose
   AST_READ_OPENS: assert property (
      @(posedge core_clk) disable iff (rst)
      (selected && strobe && !sleep_request && !wr_any && !sleeping)
      |=> !dq_oe_n)
      else $error("strobed read did not drive bus");

   // plain deselect without a strobe leaves the bus as it was
   AST_DESELECT_HOLDS: assert property (
      @(posedge core_clk) disable iff (rst)
      (!selected && !strobe && !sleep_request && !sleeping)
      |=> $stable(dq_oe_n))
      else $error("bus changed on idle deselect");

   // deselect: nothing lands, a strobe closes the bus
   AST_DESELECT_NO_WRITE: assert property (
      @(posedge core_clk) disable iff (rst)
      !selected |-> !wr_any)
      else $error("write while deselected");

   AST_DESELECT_CLOSES: assert property (
      @(posedge core_clk) disable iff (rst)
      (!selected && strobe) |=> dq_oe_n)
      else $error("deselected strobe left bus driven");

   // write width decode
   AST_GLOBAL_FULL: assert property (
      @(posedge core_clk) disable iff (rst)
      !global_write_strobe_n |-> (&lane_en))
      else $error("global write not full width");

   AST_NO_WRITE_NO_LANES: assert property (
      @(posedge core_clk) disable iff (rst)
      (global_write_strobe_n && byte_write_gate_n) |-> !(|lane_en))
      else $error("lanes enabled without write strobe");

   AST_LANES_ONLY: assert property (
      @(posedge core_clk) disable iff (rst)
      (global_write_strobe_n && !byte_write_gate_n)
      |-> (lane_en == ~per_lane_write_select_n))
      else $error("byte lanes mismatch");

   // sleep entry and high impedance in sleep
   AST_SLEEP_ENTRY: assert property (
      @(posedge core_clk) disable iff (rst)
      (sleep_request && !selected && !sleeping) |=> sleeping)
      else $error("sleep not entered");

   AST_SLEEP_HIZ: assert property (
      @(posedge core_clk) disable iff (rst)
      sleeping |-> dq_oe_n)
      else $error("bus driven in sleep");

   // only the exit edge is promised; a strobe may reopen right after
   AST_SLEEP_EXIT_HIZ: assert property (
      @(posedge core_clk) disable iff (rst)
      (sleeping && !sleep_request) |=> (dq_oe_n && !sleeping))
      else $error("bus driven on sleep exit");

   // main scenarios
   COV_READ: cover property (@(posedge core_clk) disable iff (rst)
      wr_any ##1 (selected && strobe) ##1 !dq_oe_n);
   COV_BYTE: cover property (@(posedge core_clk) disable iff (rst)
      wr_bytes && wr_any && !(&lane_en));
   COV_SLEEP: cover property (@(posedge core_clk) disable iff (rst)
      sleeping ##1 !sleeping);
   COV_DESELECT_CLOSE: cover property (@(posedge core_clk) disable iff (rst)
      !dq_oe_n ##1 (!selected && strobe) ##1 dq_oe_n);
   COV_WAKE_STROBE: cover property (@(posedge core_clk) disable iff (rst)
      sleeping && !sleep_request && selected && strobe);
endmodule : sss_top

// File: rtl/sss_pkg.sv
// Operation
// - selected only when enables low, high, low
// - global strobe or all lanes writes full width
// - outputs stay high impedance after writes until strobe
// - data lines high impedance on sleep exit
package sss_pkg;
   // ----------------------------------------------------------------
   // default geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W_DEF = 6;
   localparam int LANES_DEF  = 4;
   localparam int LANE_W_DEF = 9;
   // asserted levels of the chip enables
   localparam logic ASSERTED_LOW  = 1'h0;
   localparam logic ASSERTED_HIGH = 1'h1;
   // ----------------------------------------------------------------
   // access states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SSS_IDLE, SSS_READ, SSS_WRITE, SSS_SLEEP}
      sss_state_t;
endpackage : sss_pkg

// File: rtl/sss_mem.sv
`timescale 1ns/1ps
// byte-lane memory with registered read data
module sss_mem #(
   parameter int ADDR_W = 6,
   parameter int LANES  = 4,
   parameter int LANE_W = 9
) (
   // clock
   input  wire logic                      core_clk,
   // write port
   input  wire logic                      wr_en,
   input  wire logic [LANES-1:0]          lane_en,
   input  wire logic [ADDR_W-1:0]         addr,
   input  wire logic [LANES*LANE_W-1:0]   wr_data,
   // read port
   output logic      [LANES*LANE_W-1:0]   rd_data
);
   logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

   // per-lane write, lanes left out keep their old contents
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < LANES; i++)
      begin
         if (wr_en && lane_en[i])
         begin
            mem[addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
         end
      end
   end

   // read data always from a register
   always_ff @(posedge core_clk)
   begin
      rd_data <= mem[addr];
   end
endmodule : sss_mem

// File: dv/sss_host.sv
`timescale 1ns/1ps
// controller model, moves every pin just after the falling edge
module sss_host (
   // clock
   input  wire logic        core_clk,
   // enables {first_n, second, third_n} and strobes {pas_n, cas_n}
   output logic [2:0]       ce,
   output logic [1:0]       as_n,
   // write strobes {global_n, gate_n} and lane selects
   output logic [1:0]       wr_n,
   output logic [3:0]       lane_n,
   // address, data, sleep
   output logic [5:0]       addr,
   output logic [35:0]      dq,
   output logic             slp
);
   // idle bus at time zero: deselected, nothing strobed
   initial
   begin
      ce     = 3'h4;
      as_n   = 2'h3;
      wr_n   = 2'h3;
      lane_n = 4'hf;
      addr   = 6'h0;
      dq     = 36'h0;
      slp    = 1'h0;
   end
   // one bus cycle; a sleep request always goes out deselected
   task cyc(input logic [2:0] c, input logic [1:0] s, input logic [1:0] w,
            input logic [3:0] l, input logic [5:0] a,
            input logic [35:0] d, input logic z);
      @(negedge core_clk);
      ce     <= z ? (c | 3'h4) : c;
      as_n   <= s;
      wr_n   <= w;
      lane_n <= l;
      addr   <= a;
      dq     <= (w == 2'h3) ? ~dq : d; // released data keeps moving
      slp    <= z;
   endtask : cyc
endmodule : sss_host

// File: dv/sss_top_tb.sv
`timescale 1ns/1ps
module sss_top_tb;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic [2:0] ce;
   logic [1:0] as_n, wr_n;
   logic [3:0] lane_n;
   logic [5:0] addr;
   logic [35:0] dq_in, dq_out;
   logic dq_oe_n, sleeping, slp;
   int miscompares = 0, comparisons = 0, cycles = 0;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [35:0] M = 36'h007fc01ff; // lanes 0 and 2
   sss_host i_sss_host (.core_clk(core_clk), .ce(ce), .as_n(as_n),
      .wr_n(wr_n), .lane_n(lane_n), .addr(addr), .dq(dq_in), .slp(slp));
   sss_top i_sss_top (.core_clk(core_clk), .rst(rst),
      .chip_enable_first_low_n(ce[2]), .chip_enable_second_high(ce[1]),
      .chip_enable_third_low_n(ce[0]), .processor_address_strobe_n(as_n[1]),
      .controller_address_strobe_n(as_n[0]), .addr(addr),
      .global_write_strobe_n(wr_n[1]), .byte_write_gate_n(wr_n[0]),
      .per_lane_write_select_n(lane_n), .sleep_request(slp),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .sleeping(sleeping));
   // clock and hang guard
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   task check(input string what, input logic [35:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task idle(input logic z);
      i_sss_host.cyc(3'h4, 2'h3, 2'h3, 4'hf, 6'h0, 36'h0, z);
   endtask : idle
   task wr(input logic [5:0] a, input logic [1:0] w, input logic [3:0] l,
           input logic [35:0] d);
      i_sss_host.cyc(SEL, 2'h3, w, l, a, d, 1'h0);
   endtask : wr
   // read, then a deselected cycle that keeps the bus open
   task rd_chk(input logic [5:0] a, input logic [1:0] s, input logic [35:0] e);
      i_sss_host.cyc(SEL, s, 2'h3, 4'hf, a, 36'h0, 1'h0);
      i_sss_host.cyc(3'h4, 2'h3, 2'h3, 4'hf, a, 36'h0, 1'h0);
      check("oe", {35'h0, dq_oe_n}, 36'h0);
      check("data", dq_out, e);
   endtask : rd_chk
   task test_writes;
      wr(6'h1, 2'h1, 4'ha, 36'h123456789);
      wr(6'h2, 2'h2, 4'h0, 36'h9abcdef01);
      wr(6'h1, 2'h2, 4'ha, 36'hfffffffff);
      wr(6'h2, 2'h3, 4'h0, 36'h0);
      repeat (2)
      begin
         wr(6'h2, 2'h3, 4'hf, 36'h0);
         check("oe", {35'h0, dq_oe_n}, 36'h1);
      end
      rd_chk(6'h1, 2'h1, (36'h123456789 & ~M) | M);
      rd_chk(6'h2, 2'h2, 36'h9abcdef01);
      wr(6'h2, 2'h1, 4'hf, 36'h0);
      idle(1'h0);
      check("oe", {35'h0, dq_oe_n}, 36'h1);
   endtask : test_writes
   task test_select;
      wr(6'h3, 2'h1, 4'hf, 36'h0aaaaaaaa);
      // open the bus first so that deselected strobes must close it
      rd_chk(6'h3, 2'h1, 36'h0aaaaaaaa);
      for (int i = 0; i < 8; i++)
         if (i != 2)
            i_sss_host.cyc(i[2:0], 2'h1, 2'h1, 4'h0, 6'h3, 36'h5, 1'h0);
      check("oe", {35'h0, dq_oe_n}, 36'h1);
      rd_chk(6'h3, 2'h1, 36'h0aaaaaaaa);
   endtask : test_select
   task test_sleep;
      idle(1'h1);
      idle(1'h1);
      check("sleeping", {35'h0, sleeping}, 36'h1);
      // a read strobed on the exit edge must not open the bus
      i_sss_host.cyc(SEL, 2'h1, 2'h3, 4'hf, 6'h1, 36'h0, 1'h0);
      idle(1'h0);
      check("sleeping", {35'h0, sleeping}, 36'h0);
      check("oe", {35'h0, dq_oe_n}, 36'h1);
   endtask : test_sleep
   // main sequence, inputs move on the falling edge
   initial
   begin
      repeat (16) @(negedge core_clk);
      rst = 1'h0;
      check("oe", {35'h0, dq_oe_n}, 36'h1);
      test_writes();
      test_select();
      test_sleep();
      complete_run();
   end
endmodule : sss_top_tb
